// ---- pkg/vft_map.vh ----
// register map, field codes and fixed values of the virtual frame trigger block
`ifndef VFT_MAP_VH
`define VFT_MAP_VH
`define VFT_AW 4
`define VFT_DW 32
`define VFT_LW 16
// register offsets
`define VFT_REG_CTRL 4'h0
`define VFT_REG_DETECT 4'h1
`define VFT_REG_SIGTYPE 4'h2
`define VFT_REG_LINES 4'h3
`define VFT_REG_LTPER 4'h4
`define VFT_REG_STATUS 4'h5
`define VFT_REG_USED_CNT 4'h6
`define VFT_REG_IGN_CNT 4'h7
`define VFT_REG_END_CNT 4'h8
`define VFT_REG_LINE_CNT 4'h9
`define VFT_REG_PROBLEM 4'ha
// ctrl bit positions
`define VFT_CTRL_TRIG_EN 0
`define VFT_CTRL_GRAB 1
`define VFT_CTRL_VARIABLE 2
`define VFT_CTRL_LT_SRC 3
// detection codes
`define VFT_DET_LOW 7'h01
`define VFT_DET_HIGH 7'h02
`define VFT_DET_RISE 7'h04
`define VFT_DET_FALL 7'h08
`define VFT_DET_DUAL_RISE 7'h20
`define VFT_DET_DUAL_FALL 7'h40
// signal type codes
`define VFT_SIG_TTL 7'h01
`define VFT_SIG_DIFF 7'h02
`define VFT_SIG_24V 7'h08
`define VFT_SIG_12V 7'h40
// reset values
`define VFT_RST_LINES 16'h000a
`define VFT_RST_LTPER 16'h0100
`define VFT_RST_DETECT 7'h04
`define VFT_RST_SIGTYPE 7'h01
`endif

// ---- logic/vft_event_cnt.v ----
// saturating-free wrap counter for one trigger event class
`timescale 1ns/1ps
`include "vft_map.vh"
module vft_event_cnt (
	mclk,
	rst_n,
	clr,
	inc,
	count
);
	input wire mclk;
	input wire rst_n;
	input wire clr;
	input wire inc;
	output reg [`VFT_LW-1:0] count;

	// clear wins only when no event in the same cycle; else restart at one
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
		end else if (clr) begin
			count <= inc ? 16'h0001 : 16'h0000;
		end else if (inc) begin
			count <= count + 16'h0001;
		end
	end
endmodule // vft_event_cnt

// ---- logic/vft_frame_trigger.v ----
// virtual frame trigger control for a line-scan frame grabber
`timescale 1ns/1ps
`include "vft_map.vh"
// Notes on behaviour
// - frame trigger picks first stored line
// - fixed mode stores exactly configured lines
// - variable mode trigger-controlled, capped at maximum; the code caps rise and fall only, level and dual roll over at the maximum
// - level and dual modes roll over
// - edge modes take one frame, no rollover
// - two trigger inputs, one and two
// - camera line trigger always runs
// - line trigger from encoder or internal
// - trigger events only while grabbing
// - fixed level: recheck level at frame end
// - fixed mode: every trigger used or ignored
// - variable mode never reports ignored triggers
// - variable edge: edge starts, level sets length
// - enable bit: one on, zero off
// - detection codes 1,2,4,8,32,64 decoded
// - dual: input one starts, two ends
// - signal type setting held
// - monitor acquisition and transfer, report problems
// - used or ignored event per trigger
// - end event on second pulse or level end
module vft_frame_trigger (
	mclk,
	arst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	trig_in1,
	trig_in2,
	encoder_line_trig,
	cam_line_valid,
	xfer_overflow,
	cam_line_trig,
	line_store,
	frame_first_line,
	frame_active,
	trigger_used_event,
	trigger_ignored_event,
	trigger_end_event
);
	input wire mclk;
	input wire arst_n;
	input wire [`VFT_AW-1:0] reg_addr;
	input wire [`VFT_DW-1:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [`VFT_DW-1:0] reg_rdata;
	input wire trig_in1;
	input wire trig_in2;
	input wire encoder_line_trig;
	input wire cam_line_valid;
	input wire xfer_overflow;
	output reg cam_line_trig;
	output reg line_store;
	output reg frame_first_line;
	output wire frame_active;
	output reg trigger_used_event;
	output reg trigger_ignored_event;
	output reg trigger_end_event;

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_GRAB = 3'b100;

	reg rst_s1_r;
	reg rst_n_r;
	reg [3:0] ctrl_r;
	reg [6:0] detect_r;
	reg [6:0] sigtype_r;
	reg [`VFT_LW-1:0] lines_r;
	reg [`VFT_LW-1:0] ltper_r;
	reg [`VFT_LW-1:0] ltcnt_r;
	reg [`VFT_LW-1:0] line_cnt_r;
	reg [`VFT_LW-1:0] line_cnt_nxt;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg t1_d_r;
	reg t2_d_r;
	reg dual_on_r;
	reg ovf_r;
	reg cam_miss_r;
	reg store_nxt;
	reg first_nxt;
	reg used_nxt;
	reg ign_nxt;
	reg end_nxt;
	wire trig_en;
	wire grab;
	wire variable;
	wire lt_src_enc;
	wire is_low;
	wire is_high;
	wire is_rise;
	wire is_fall;
	wire is_dual_r;
	wire is_dual_f;
	wire is_level;
	wire is_dual;
	wire level_on;
	wire edge_start;
	wire edge_end;
	wire start_ev;
	wire level_keep;
	wire last_line;
	wire internal_lt;
	wire [`VFT_LW-1:0] used_cnt;
	wire [`VFT_LW-1:0] ign_cnt;
	wire [`VFT_LW-1:0] end_cnt;
	wire stat_clr;

	// reset released through two flops so all logic leaves reset together
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	assign trig_en = ctrl_r[`VFT_CTRL_TRIG_EN];
	assign grab = ctrl_r[`VFT_CTRL_GRAB];
	assign variable = ctrl_r[`VFT_CTRL_VARIABLE];
	assign lt_src_enc = ctrl_r[`VFT_CTRL_LT_SRC];
	assign stat_clr = reg_wr && (reg_addr == `VFT_REG_STATUS);

	// detection decode; an unknown code matches nothing and no frame starts
	assign is_low = (detect_r == `VFT_DET_LOW);
	assign is_high = (detect_r == `VFT_DET_HIGH);
	assign is_rise = (detect_r == `VFT_DET_RISE);
	assign is_fall = (detect_r == `VFT_DET_FALL);
	assign is_dual_r = (detect_r == `VFT_DET_DUAL_RISE);
	assign is_dual_f = (detect_r == `VFT_DET_DUAL_FALL);
	assign is_level = is_low | is_high;
	assign is_dual = is_dual_r | is_dual_f;

	// trigger inputs are synchronous; previous value kept for edge finding;
	// dual window stays open from a start edge until the end edge or idle
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			t1_d_r <= 1'b0;
			t2_d_r <= 1'b0;
			dual_on_r <= 1'b0;
		end else begin
			t1_d_r <= trig_in1;
			t2_d_r <= trig_in2;
			dual_on_r <= is_dual & (state_r != ST_IDLE) & (dual_on_r | edge_start) & ~edge_end;
		end
	end

	// input one carries start edges and levels, input two the dual end
	assign level_on = (is_low & ~trig_in1) | (is_high & trig_in1);
	assign edge_start = ((is_rise | is_dual_r) & trig_in1 & ~t1_d_r) |
		((is_fall | is_dual_f) & ~trig_in1 & t1_d_r);
	assign edge_end = (is_dual_r & trig_in2 & ~t2_d_r) |
		(is_dual_f & ~trig_in2 & t2_d_r);
	// a level counts as a trigger for as long as it is present, an edge only when it occurs
	assign start_ev = is_level ? level_on : edge_start;
	assign level_keep = is_level ? level_on : ((is_rise & trig_in1) | (is_fall & ~trig_in1));
	assign last_line = (line_cnt_r == lines_r - 16'h0001);

	// internal line trigger period counter, free running
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ltcnt_r <= 16'h0000;
		end else if (ltcnt_r >= ltper_r) begin
			ltcnt_r <= 16'h0000;
		end else begin
			ltcnt_r <= ltcnt_r + 16'h0001;
		end
	end
	assign internal_lt = (ltcnt_r == 16'h0000);

	// camera keeps getting line triggers whatever the frame state,
	// so the first line of a frame is never a stale, corrupted one
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cam_line_trig <= 1'b0;
		end else begin
			cam_line_trig <= lt_src_enc ? encoder_line_trig : internal_lt;
		end
	end

	// frame sequencer
	always @* begin
		state_nxt = state_r;
		line_cnt_nxt = line_cnt_r;
		store_nxt = 1'b0;
		first_nxt = 1'b0;
		used_nxt = 1'b0;
		ign_nxt = 1'b0;
		end_nxt = 1'b0;
		case (state_r)
		ST_IDLE: begin
			line_cnt_nxt = 16'h0000;
			if (trig_en && grab) begin
				state_nxt = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (!trig_en || !grab) begin
				state_nxt = ST_IDLE;
			end else if (start_ev) begin
				used_nxt = 1'b1;
				state_nxt = ST_GRAB;
				line_cnt_nxt = 16'h0000;
			end
		end
		ST_GRAB: begin
			if (!trig_en || !grab) begin
				state_nxt = ST_IDLE;
			end else begin
				// a trigger edge arriving mid-frame yields no image
				if (edge_start && !is_level && !variable) begin
					ign_nxt = 1'b1;
				end
				if (cam_line_valid) begin
					store_nxt = 1'b1;
					first_nxt = (line_cnt_r == 16'h0000);
					line_cnt_nxt = line_cnt_r + 16'h0001;
					if (last_line) begin
						// frame full: level/dual may roll over, edge may not
						line_cnt_nxt = 16'h0000;
						if (is_level && level_on) begin
							used_nxt = 1'b1;
						end else if (is_dual && dual_on_r && !edge_end) begin
							used_nxt = 1'b1;
						end else begin
							state_nxt = ST_WAIT;
						end
					end
				end
				// variable length: level end or second input closes the frame
				if (variable && !is_dual && !level_keep) begin
					end_nxt = 1'b1;
					state_nxt = ST_WAIT;
					line_cnt_nxt = 16'h0000;
				end else if (variable && is_dual && edge_end) begin
					end_nxt = 1'b1;
					state_nxt = ST_WAIT;
					line_cnt_nxt = 16'h0000;
				end else if (!variable && (edge_end || (is_level && t1_d_r != trig_in1
					&& !level_on))) begin
					end_nxt = 1'b1;
				end
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
		if (variable) begin
			ign_nxt = 1'b0;
		end
	end

	// sequencer state, line counter and event pulses, all from flops
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_IDLE;
			line_cnt_r <= 16'h0000;
			line_store <= 1'b0;
			frame_first_line <= 1'b0;
			trigger_used_event <= 1'b0;
			trigger_ignored_event <= 1'b0;
			trigger_end_event <= 1'b0;
		end else begin
			state_r <= state_nxt;
			line_cnt_r <= line_cnt_nxt;
			line_store <= store_nxt;
			frame_first_line <= first_nxt;
			trigger_used_event <= used_nxt;
			trigger_ignored_event <= ign_nxt;
			trigger_end_event <= end_nxt;
		end
	end
	assign frame_active = state_r[2];

	// problem flags: set wins over the software clear
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ovf_r <= 1'b0;
			cam_miss_r <= 1'b0;
		end else begin
			ovf_r <= xfer_overflow | (ovf_r & ~(stat_clr & reg_wdata[0]));
			cam_miss_r <= (cam_line_valid & cam_line_trig & ~lt_src_enc & (ltper_r == 16'h0000))
				| (cam_miss_r & ~(stat_clr & reg_wdata[1]));
		end
	end

	// event counters, cleared by writing the status register
	vft_event_cnt u_used (
		.mclk(mclk),
		.rst_n(rst_n_r),
		.clr(stat_clr),
		.inc(trigger_used_event),
		.count(used_cnt)
	);
	vft_event_cnt u_ign (
		.mclk(mclk),
		.rst_n(rst_n_r),
		.clr(stat_clr),
		.inc(trigger_ignored_event),
		.count(ign_cnt)
	);
	vft_event_cnt u_end (
		.mclk(mclk),
		.rst_n(rst_n_r),
		.clr(stat_clr),
		.inc(trigger_end_event),
		.count(end_cnt)
	);

	// register writes
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= 4'h0;
			detect_r <= `VFT_RST_DETECT;
			sigtype_r <= `VFT_RST_SIGTYPE;
			lines_r <= `VFT_RST_LINES;
			ltper_r <= `VFT_RST_LTPER;
		end else if (reg_wr) begin
			case (reg_addr)
			`VFT_REG_CTRL: ctrl_r <= reg_wdata[3:0];
			`VFT_REG_DETECT: detect_r <= reg_wdata[6:0];
			`VFT_REG_SIGTYPE: sigtype_r <= reg_wdata[6:0];
			`VFT_REG_LINES: lines_r <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001
				: reg_wdata[15:0];
			`VFT_REG_LTPER: ltper_r <= reg_wdata[15:0];
			default: begin
			end
			endcase
		end
	end

	// register reads, data in the following cycle only; unmapped reads zero
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
			`VFT_REG_CTRL: reg_rdata <= {28'h0000000, ctrl_r};
			`VFT_REG_DETECT: reg_rdata <= {25'h0000000, detect_r};
			`VFT_REG_SIGTYPE: reg_rdata <= {25'h0000000, sigtype_r};
			`VFT_REG_LINES: reg_rdata <= {16'h0000, lines_r};
			`VFT_REG_LTPER: reg_rdata <= {16'h0000, ltper_r};
			`VFT_REG_STATUS: reg_rdata <= {26'h0000000, state_r, frame_active,
				cam_miss_r, ovf_r};
			`VFT_REG_USED_CNT: reg_rdata <= {16'h0000, used_cnt};
			`VFT_REG_IGN_CNT: reg_rdata <= {16'h0000, ign_cnt};
			`VFT_REG_END_CNT: reg_rdata <= {16'h0000, end_cnt};
			`VFT_REG_LINE_CNT: reg_rdata <= {16'h0000, line_cnt_r};
			default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule // vft_frame_trigger

// ---- verif/vft_frame_trigger_assertions.sv ----
// port-level checks for the virtual frame trigger block
`timescale 1ns/1ps
`include "vft_map.vh"
module vft_frame_trigger_assertions (
	mclk,
	arst_n,
	reg_rd,
	reg_rdata,
	cam_line_valid,
	cam_line_trig,
	line_store,
	frame_first_line,
	frame_active,
	trigger_used_event,
	trigger_ignored_event,
	trigger_end_event
);
	input wire mclk, arst_n, reg_rd, cam_line_valid, cam_line_trig;
	input wire [`VFT_DW-1:0] reg_rdata;
	input wire line_store, frame_first_line, frame_active;
	input wire trigger_used_event, trigger_ignored_event, trigger_end_event;
	reg [9:0] gap_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// cycles since the last line trigger; the slowest source stays well under the bound
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			gap_r <= 10'h000;
		else
			gap_r <= cam_line_trig ? 10'h000 : gap_r + 10'h001;
	end
	a_store_after_line: assert property (line_store |-> $past(cam_line_valid))
		else $error("line stored without a camera line");
	a_first_is_stored: assert property (frame_first_line |-> line_store)
		else $error("first line flagged but not stored");
	a_used_ignored_excl: assert property (!(trigger_used_event && trigger_ignored_event))
		else $error("trigger both used and ignored");
	a_used_opens_frame: assert property (trigger_used_event |-> frame_active)
		else $error("used trigger without a frame");
	a_ignored_in_frame: assert property (trigger_ignored_event |-> frame_active)
		else $error("ignored trigger outside a frame");
	a_end_closes_frame: assert property (trigger_end_event |-> $past(frame_active))
		else $error("end event without a running frame");
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside the answer cycle");
	a_line_trig_live: assert property (gap_r < 10'h258)
		else $error("camera line trigger stopped");
endmodule // vft_frame_trigger_assertions
bind vft_frame_trigger vft_frame_trigger_assertions chk_u (.mclk(mclk), .arst_n(arst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_line_valid(cam_line_valid),
	.cam_line_trig(cam_line_trig), .line_store(line_store),
	.frame_first_line(frame_first_line), .frame_active(frame_active),
	.trigger_used_event(trigger_used_event), .trigger_ignored_event(trigger_ignored_event),
	.trigger_end_event(trigger_end_event));

// ---- verif/vft_camera_model.sv ----
// line scan camera and shaft encoder model at the far side
`timescale 1ns/1ps
module vft_camera_model (
	mclk,
	arst_n,
	cam_line_trig,
	slow,
	cam_line_valid,
	encoder_line_trig
);
	input wire mclk, arst_n, cam_line_trig, slow;
	output reg cam_line_valid, encoder_line_trig;
	reg [3:0] dly_r;
	reg [3:0] enc_r;
	// each trigger returns a line 3 cycles later, 6 when stalling
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dly_r <= 4'h0;
			enc_r <= 4'h0;
			cam_line_valid <= 1'b0;
			encoder_line_trig <= 1'b0;
		end else begin
			if (cam_line_trig)
				dly_r <= slow ? 4'h6 : 4'h3;
			else if (dly_r != 4'h0)
				dly_r <= dly_r - 4'h1;
			cam_line_valid <= (dly_r == 4'h1);
			enc_r <= (enc_r == 4'h9) ? 4'h0 : enc_r + 4'h1;
			encoder_line_trig <= (enc_r == 4'h9);
		end
	end
endmodule // vft_camera_model

// ---- verif/virtual_frame_trigger_bench.sv ----
// self-checking bench for the virtual frame trigger block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end
module virtual_frame_trigger_bench;
	reg mclk, arst_n, reg_wr, reg_rd, trig_in1, trig_in2, xfer_overflow, slow, rd_d, act, edg;
	reg [3:0] reg_addr;
	reg [31:0] reg_wdata, got, e, m;
	reg [6:0] det;
	wire [31:0] reg_rdata;
	wire cam_line_trig, line_store, frame_first_line, enc, clv;
	integer checks, mismatches, stores, firsts, ltrigs, s0, f0, i, u, seed;
	reg [31:0] exp_q[$], msk_q[$];
	string n, nm_q[$];
	vft_frame_trigger dut_u (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trig_in1(trig_in1), .trig_in2(trig_in2), .encoder_line_trig(enc),
		.cam_line_valid(clv), .xfer_overflow(xfer_overflow), .cam_line_trig(cam_line_trig),
		.line_store(line_store), .frame_first_line(frame_first_line), .frame_active(),
		.trigger_used_event(), .trigger_ignored_event(), .trigger_end_event());
	vft_camera_model cam_u (.mclk(mclk), .arst_n(arst_n), .cam_line_trig(cam_line_trig),
		.slow(slow), .cam_line_valid(clv), .encoder_line_trig(enc));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// watcher: counts line outputs and checks each read answer against the oldest note
	always @(posedge mclk) begin
		rd_d <= reg_rd;
		if (line_store === 1'b1) stores++;
		if (frame_first_line === 1'b1) firsts++;
		if (cam_line_trig === 1'b1) ltrigs++;
		if (rd_d === 1'b1) begin
			n = nm_q.pop_front();
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			got = reg_rdata;
			`CHK(n, e, reg_rdata & m)
		end
	end
	task wr(input [3:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
			@(posedge mclk);
		end
	endtask
	// the note goes in the queue before the strobe; the extra edge lets got settle
	task rd(input [3:0] a, input [31:0] x, input [31:0] k, input string s);
		begin
			exp_q.push_back(x & k);
			msk_q.push_back(k);
			nm_q.push_back(s);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		#100000;
		mismatches++;
		$display("ERROR watchdog expected done seen hang");
		stop_test;
	end
	initial begin
		seed = 32'h9cdd;
		{checks, mismatches, stores, firsts, ltrigs} = 0;
		{arst_n, reg_wr, reg_rd, trig_in1, trig_in2, xfer_overflow, slow} = 7'h00;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(4'h1, 32'h4, 32'h7f, "detect");
		rd(4'h2, 32'h1, 32'h7f, "sigtype");
		rd(4'h3, 32'ha, 32'hffff, "lines");
		rd(4'h5, 32'h8, 32'h3f, "status");
		wr(4'h2, 32'h8);
		rd(4'h2, 32'h8, 32'h7f, "sigtype");
		wr(4'hf, $random(seed));
		rd(4'hf, 32'h0, 32'hffffffff, "unmapped");
		$display("register test done");
		// fixed frames, 4 lines, one line every 8 cycles; codes low, high, rise, fall
		wr(4'h4, 32'h7);
		wr(4'h3, 32'h4);
		for (i = 0; i < 4; i++) begin
			act = (i == 1) || (i == 2);
			edg = (i >= 2);
			trig_in1 <= ~act;
			wr(4'h1, 32'h1 << i);
			wr(4'h5, 32'h3);
			wr(4'h0, 32'h3);
			s0 = stores;
			f0 = firsts;
			trig_in1 <= act;
			if (edg) begin
				repeat (12) @(posedge mclk);
				trig_in1 <= ~act;
				repeat (2) @(posedge mclk);
				trig_in1 <= act;
			end
			repeat (80) @(posedge mclk);
			trig_in1 <= ~act;
			repeat (60) @(posedge mclk);
			rd(4'h6, edg ? 32'h1 : 32'h3, 32'hffff, "used");
			u = got;
			rd(4'h7, edg, 32'hffff, "ignored");
			`CHK("rollover", !edg, u > 1)
			`CHK("stores", 4 * u, stores - s0)
			`CHK("first lines", u, firsts - f0)
			wr(4'h0, 32'h0);
			rd(4'h5, 32'h8, 32'h38, "idle");
		end
		$display("fixed test done");
		// variable frames with a stalling camera: high level, dual rise, dual fall, rise edge
		wr(4'h3, 32'h20);
		slow <= 1'b1;
		for (i = 0; i < 4; i++) begin
			det = (i == 0) ? 7'h02 : (i == 3) ? 7'h04 : 7'h10 << i;
			act = (i != 2);
			trig_in1 <= ~act;
			trig_in2 <= ~act;
			wr(4'h1, {25'h0, det});
			wr(4'h5, 32'h3);
			wr(4'h0, 32'h7);
			s0 = stores;
			trig_in1 <= act;
			repeat (24 + ($random(seed) & 15)) @(posedge mclk);
			if (i == 0 || i == 3)
				trig_in1 <= ~act;
			else
				trig_in2 <= act;
			repeat (30) @(posedge mclk);
			rd(4'h8, 32'h1, 32'hffff, "end events");
			rd(4'h7, 32'h0, 32'hffff, "ignored");
			rd(4'h6, 32'h1, 32'hffff, "used");
			`CHK("capped", 1'b1, (stores > s0) && (stores - s0 < 32))
			wr(4'h0, 32'h0);
		end
		slow <= 1'b0;
		$display("variable test done");
		// no frames without both trigger enable and grab
		wr(4'h1, 32'h4);
		for (i = 1; i < 3; i++) begin
			trig_in1 <= 1'b0;
			wr(4'h5, 32'h3);
			wr(4'h0, i);
			s0 = stores;
			trig_in1 <= 1'b1;
			repeat (40) @(posedge mclk);
			rd(4'h6, 32'h0, 32'hffff, "used");
			`CHK("no stores", 0, stores - s0)
		end
		// reset in mid-frame: logic must come back idle with its counter cleared
		trig_in1 <= 1'b0;
		wr(4'h0, 32'h3);
		trig_in1 <= 1'b1;
		repeat (16) @(posedge mclk);
		rd(4'h5, 32'h24, 32'h3c, "grabbing");
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(4'h9, 32'h0, 32'hffff, "line count");
		rd(4'h5, 32'h8, 32'h3f, "status");
		rd(4'h0, 32'h0, 32'hf, "ctrl");
		xfer_overflow <= 1'b1;
		@(posedge mclk);
		xfer_overflow <= 1'b0;
		rd(4'h5, 32'h1, 32'h1, "overflow");
		wr(4'h5, 32'h1);
		rd(4'h5, 32'h0, 32'h1, "overflow");
		// encoder as line trigger source, internal period made long
		wr(4'h4, 32'h100);
		wr(4'h0, 32'h8);
		s0 = ltrigs;
		repeat (100) @(posedge mclk);
		`CHK("encoder lines", 1'b1, ltrigs - s0 >= 9)
		$display("control test done");
		stop_test;
	end
endmodule // virtual_frame_trigger_bench
